//--- rtl/sgd_ca_decoder.sv
/*
 * command/address packet decoder: one sys_clk cycle per command clock cycle,
 * rising and falling halves presented together, mode registers held here.
 * assumes the front end has already captured both edges synchronously.
 */
// What this block does
// - l->h clock-enable with all-high tops is power-down entry outside training; h->l is an exit
// - undo bus inversion when enabled and flag low, before decoding
// - mode register write stores 12-bit opcode in the 4-bit addressed register
// - row open carries 4-bit bank and 14-bit row
// - reads and writes carry bank and 7-bit column, no sub-word start
// - masked writes take one shared or two per-byte mask pairs afterwards
// - falling-edge gate bit high enables the data access, low suppresses it
// - refresh family: enable low twice is refresh, low then high outside training is self-refresh entry
// - fifo load carries 4-bit burst position and 10-bit data
// - all three no-operation encodings raise no command; the alternate two set bad_nop_q outside training
// - register fifteen write with enable high twice allowed only in training
// - precharge/refresh bank from rising bits 7..4, falling bit 4 selects all
// - auto-close write variants differ only by falling bit 4 high
// - packet is one rising plus falling edge, enable sampled previous and now
// - second pseudo-channel supplies its own low column lines and gate
`timescale 1ns/1ps
`default_nettype none
module sgd_ca_decoder (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [9:0] ca_rise,
   input wire logic [9:0] ca_fall,
   input wire logic [3:0] pc1_ca_rise,
   input wire logic [3:0] pc1_ca_fall,
   input wire logic cke_n,
   input wire logic cmd_bus_invert_flag_n,
   input wire logic bus_invert_en,
   input wire logic training_mode,
   input wire logic pseudo_channel_mode,
   input wire logic [3:0] mr_sel,
   output logic cmd_valid_q,
   output sgd_pkg::sgd_cmd_t cmd_code_q,
   output logic [3:0] bank_q,
   output logic [13:0] row_q,
   output logic [6:0] col_pc0_q,
   output logic [6:0] col_pc1_q,
   output logic ce_pc0_q,
   output logic ce_pc1_q,
   output logic auto_close_q,
   output logic [3:0] mr_addr_q,
   output logic [11:0] mr_op_q,
   output logic [3:0] fifo_pos_q,
   output logic [9:0] fifo_data_q,
   output logic [15:0] beat_mask0_q,
   output logic [15:0] beat_mask1_q,
   output logic in_power_down_q,
   output logic in_self_refresh_q,
   output logic bad_nop_q,
   output logic [11:0] mr_rdata_q
);
   // ==========================================================================
   // logical command words
   logic [9:0] r;
   logic [9:0] f;
   logic [3:0] r1;
   logic [3:0] f1;
   logic cke_prev_q;
   sgd_pkg::sgd_st_t st_q;
   sgd_pkg::sgd_cmd_t dec;
   logic dec_hit;
   logic nop_alt;
   logic [11:0] mode_reg [sgd_pkg::MR_N];
   logic ll;
   logic lh;
   logic hl;
   logic hh;

   sgd_ca_uninvert #(.W(sgd_pkg::CA_W)) u_inv_r (.raw(ca_rise), .inv_en(bus_invert_en),
      .flag_n(cmd_bus_invert_flag_n), .logical(r));
   sgd_ca_uninvert #(.W(sgd_pkg::CA_W)) u_inv_f (.raw(ca_fall), .inv_en(bus_invert_en),
      .flag_n(cmd_bus_invert_flag_n), .logical(f));
   sgd_ca_uninvert #(.W(sgd_pkg::LOW_W)) u_inv_r1 (.raw(pc1_ca_rise), .inv_en(bus_invert_en),
      .flag_n(cmd_bus_invert_flag_n), .logical(r1));
   sgd_ca_uninvert #(.W(sgd_pkg::LOW_W)) u_inv_f1 (.raw(pc1_ca_fall), .inv_en(bus_invert_en),
      .flag_n(cmd_bus_invert_flag_n), .logical(f1));

   // ==========================================================================
   // clock-enable history: previous and current cycle form part of the decode
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         cke_prev_q <= 1'b1;
      else
         cke_prev_q <= cke_n;
   end

   assign ll = !cke_prev_q && !cke_n;
   assign lh = !cke_prev_q && cke_n;
   assign hl = cke_prev_q && !cke_n;
   assign hh = cke_prev_q && cke_n;

   // ==========================================================================
   // packet decode; nothing is decoded while mask pairs are being collected
   always_comb
   begin
      dec = sgd_pkg::CMD_NOP;
      dec_hit = 1'b0;
      nop_alt = 1'b0;
      if (st_q == sgd_pkg::ST_IDLE)
      begin
         if (lh && training_mode)
            dec = sgd_pkg::CMD_BUS_TRAINING_CAPTURE; // lines are don't-care
         else if (lh && r[9:8] == sgd_pkg::PAIR_HH && f[9:8] == sgd_pkg::PAIR_HH)
            dec = sgd_pkg::CMD_POWER_DOWN_ENTRY;
         else if (lh && r[9:8] == sgd_pkg::PAIR_HL && f[9:8] == sgd_pkg::PAIR_LH)
            dec = sgd_pkg::CMD_SELF_REFRESH_ENTRY;
         else if (hl && r[9:8] == sgd_pkg::PAIR_HH && f[9:8] == sgd_pkg::PAIR_HH)
            dec = in_self_refresh_q ? sgd_pkg::CMD_SELF_REFRESH_EXIT
                                    : sgd_pkg::CMD_POWER_DOWN_EXIT;
         else if (hh && training_mode && r[9:8] == sgd_pkg::PAIR_HL
                  && f[9:8] == sgd_pkg::PAIR_HL && r[7:4] == sgd_pkg::MR_FIFTEEN)
            dec = sgd_pkg::CMD_MODE_REGISTER_WRITE;
         else if (ll && !r[sgd_pkg::OP_HI])
            dec = sgd_pkg::CMD_ROW_OPEN;
         else if (ll && r[9:8] == sgd_pkg::PAIR_HH)
         begin
            unique case (f[9:8])
               sgd_pkg::PAIR_LH:
                  unique case (f[7:6])
                     sgd_pkg::PAIR_LL: dec = sgd_pkg::CMD_READ;
                     sgd_pkg::PAIR_HL: dec = sgd_pkg::CMD_FIFO_LOAD;
                     sgd_pkg::PAIR_HH: dec = sgd_pkg::CMD_READ_TRAIN;
                     sgd_pkg::PAIR_LH: dec = sgd_pkg::CMD_NOP; // undefined, ignored
                  endcase
               sgd_pkg::PAIR_LL:
                  unique case (f[7:6])
                     sgd_pkg::PAIR_LL: dec = sgd_pkg::CMD_WRITE;
                     sgd_pkg::PAIR_LH: dec = sgd_pkg::CMD_WRITE_PER_BYTE_MASK;
                     sgd_pkg::PAIR_HL: dec = sgd_pkg::CMD_WRITE_SHARED_MASK;
                     sgd_pkg::PAIR_HH: dec = sgd_pkg::CMD_WRITE_TRAIN;
                  endcase
               sgd_pkg::PAIR_HL: nop_alt = 1'b1; // second encoding
               sgd_pkg::PAIR_HH: dec = sgd_pkg::CMD_NOP; // first encoding
            endcase
         end
         else if (ll && r[9:8] == sgd_pkg::PAIR_HL)
         begin
            unique case (f[9:8])
               sgd_pkg::PAIR_HH: nop_alt = 1'b1; // third encoding
               sgd_pkg::PAIR_HL: dec = sgd_pkg::CMD_MODE_REGISTER_WRITE;
               sgd_pkg::PAIR_LL: dec = f[sgd_pkg::ALL_BIT] ? sgd_pkg::CMD_PRECHARGE_ALL_BANKS
                                      : sgd_pkg::CMD_PRECHARGE_ONE_BANK;
               sgd_pkg::PAIR_LH: dec = f[sgd_pkg::ALL_BIT] ? sgd_pkg::CMD_REFRESH_ALL_BANKS
                                      : sgd_pkg::CMD_REFRESH_ONE_BANK;
            endcase
         end
         dec_hit = (dec != sgd_pkg::CMD_NOP);
      end
   end

   // ==========================================================================
   // command fields: latched at decode and held through mask collection
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cmd_code_q <= sgd_pkg::CMD_NOP;
         bank_q <= 4'h0;
         row_q <= 14'h0000;
         col_pc0_q <= 7'h00;
         col_pc1_q <= 7'h00;
         ce_pc0_q <= 1'b0;
         ce_pc1_q <= 1'b0;
         auto_close_q <= 1'b0;
         mr_addr_q <= 4'h0;
         mr_op_q <= 12'h000;
         fifo_pos_q <= 4'h0;
         fifo_data_q <= 10'h000;
      end
      else if (dec_hit)
      begin
         cmd_code_q <= dec;
         bank_q <= r[sgd_pkg::BANK_HI:sgd_pkg::BANK_LO];
         row_q <= {f, r[sgd_pkg::LOW_HI:0]};
         col_pc0_q <= {f[sgd_pkg::COLHI_HI:0], r[sgd_pkg::LOW_HI:0]};
         // separate low column lines only when the channel is split
         col_pc1_q <= pseudo_channel_mode ? {f1[sgd_pkg::COLHI_HI:0], r1}
                      : {f[sgd_pkg::COLHI_HI:0], r[sgd_pkg::LOW_HI:0]};
         ce_pc0_q <= f[sgd_pkg::CE_BIT];
         ce_pc1_q <= pseudo_channel_mode ? f1[sgd_pkg::CE_BIT] : f[sgd_pkg::CE_BIT];
         auto_close_q <= f[sgd_pkg::ALL_BIT];
         mr_addr_q <= r[sgd_pkg::BANK_HI:sgd_pkg::BANK_LO];
         mr_op_q <= {f[sgd_pkg::BYTE_HI:0], r[sgd_pkg::LOW_HI:0]};
         fifo_pos_q <= r[sgd_pkg::BANK_HI:sgd_pkg::BANK_LO];
         fifo_data_q <= {f[5:0], r[sgd_pkg::LOW_HI:0]};
      end
   end

   // ==========================================================================
   // mask sequencer: valid is held back until every mask pair has arrived
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_q <= sgd_pkg::ST_IDLE;
         cmd_valid_q <= 1'b0;
         beat_mask0_q <= 16'h0000;
         beat_mask1_q <= 16'h0000;
      end
      else
      begin
         cmd_valid_q <= 1'b0;
         unique case (st_q)
            sgd_pkg::ST_IDLE:
               if (dec == sgd_pkg::CMD_WRITE_SHARED_MASK || dec == sgd_pkg::CMD_WRITE_PER_BYTE_MASK)
                  st_q <= sgd_pkg::ST_MASK_A;
               else
                  cmd_valid_q <= dec_hit; // no-ops never raise valid
            sgd_pkg::ST_MASK_A:
            begin
               beat_mask0_q <= {f[sgd_pkg::BYTE_HI:0], r[sgd_pkg::BYTE_HI:0]}; // byte 0
               if (cmd_code_q == sgd_pkg::CMD_WRITE_SHARED_MASK)
               begin
                  beat_mask1_q <= {f[sgd_pkg::BYTE_HI:0], r[sgd_pkg::BYTE_HI:0]};
                  cmd_valid_q <= 1'b1;
                  st_q <= sgd_pkg::ST_IDLE;
               end
               else
                  st_q <= sgd_pkg::ST_MASK_B;
            end
            sgd_pkg::ST_MASK_B:
            begin
               beat_mask1_q <= {f[sgd_pkg::BYTE_HI:0], r[sgd_pkg::BYTE_HI:0]}; // byte 1
               cmd_valid_q <= 1'b1;
               st_q <= sgd_pkg::ST_IDLE;
            end
            default: st_q <= sgd_pkg::ST_IDLE;
         endcase
      end
   end

   // ==========================================================================
   // low-power state; an h->l exit closes self-refresh if it is open, otherwise power-down
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         in_power_down_q <= 1'b0;
         in_self_refresh_q <= 1'b0;
      end
      else
      begin
         if (dec == sgd_pkg::CMD_POWER_DOWN_ENTRY)
            in_power_down_q <= 1'b1;
         else if (dec == sgd_pkg::CMD_POWER_DOWN_EXIT)
            in_power_down_q <= 1'b0;
         if (dec == sgd_pkg::CMD_SELF_REFRESH_ENTRY)
            in_self_refresh_q <= 1'b1;
         else if (dec == sgd_pkg::CMD_SELF_REFRESH_EXIT)
            in_self_refresh_q <= 1'b0;
      end
   end

   // ==========================================================================
   // flags a controller using the alternate no-ops outside training
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         bad_nop_q <= 1'b0;
      else
         bad_nop_q <= nop_alt && !training_mode;
   end

   // ==========================================================================
   // mode register storage with a read port for observation
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < sgd_pkg::MR_N; i++)
            mode_reg[i] <= 12'h000;
         mr_rdata_q <= 12'h000;
      end
      else
      begin
         if (dec == sgd_pkg::CMD_MODE_REGISTER_WRITE)
            mode_reg[r[sgd_pkg::BANK_HI:sgd_pkg::BANK_LO]] <=
               {f[sgd_pkg::BYTE_HI:0], r[sgd_pkg::LOW_HI:0]};
         mr_rdata_q <= mode_reg[mr_sel];
      end
   end

   // ==========================================================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   sequence s_byte_mask_start;
      st_q == sgd_pkg::ST_IDLE && dec == sgd_pkg::CMD_WRITE_PER_BYTE_MASK;
   endsequence
   sequence s_two_pairs_then_valid;
      !cmd_valid_q ##1 !cmd_valid_q ##1 (cmd_valid_q && cmd_code_q == sgd_pkg::CMD_WRITE_PER_BYTE_MASK);
   endsequence

   property p_pde;
      lh && !training_mode && r[9:8] == sgd_pkg::PAIR_HH && f[9:8] == sgd_pkg::PAIR_HH
         && st_q == sgd_pkg::ST_IDLE |=> cmd_valid_q && in_power_down_q;
   endproperty
   a_pde: assert property (p_pde) else $error("power-down entry missed");
   property p_refresh_vs_sre;
      ll && st_q == sgd_pkg::ST_IDLE && r[9:8] == sgd_pkg::PAIR_HL && f[9:8] == sgd_pkg::PAIR_LH
         |=> cmd_valid_q && $stable(in_self_refresh_q)
             && (cmd_code_q == sgd_pkg::CMD_REFRESH_ONE_BANK
                 || cmd_code_q == sgd_pkg::CMD_REFRESH_ALL_BANKS);
   endproperty
   a_refresh_vs_sre: assert property (p_refresh_vs_sre) else $error("refresh decode wrong");
   property p_bank_uninverted;
      dec_hit |=>
         bank_q == ($past(bus_invert_en && !cmd_bus_invert_flag_n) ? ~$past(ca_rise[7:4])
                    : $past(ca_rise[7:4]));
   endproperty
   a_bank_uninverted: assert property (p_bank_uninverted) else $error("bank not uninverted");
   property p_mr_store;
      cmd_valid_q && cmd_code_q == sgd_pkg::CMD_MODE_REGISTER_WRITE |-> mode_reg[mr_addr_q] == mr_op_q;
   endproperty
   a_mr_store: assert property (p_mr_store) else $error("mode register not loaded");
   property p_byte_masks;
      s_byte_mask_start |=> s_two_pairs_then_valid;
   endproperty
   a_byte_masks: assert property (p_byte_masks) else $error("per-byte mask timing wrong");
   property p_gate;
      dec == sgd_pkg::CMD_READ && !f[sgd_pkg::CE_BIT] |=> !ce_pc0_q && cmd_valid_q;
   endproperty
   a_gate: assert property (p_gate) else $error("gate bit not honoured");
   property p_nop;
      st_q == sgd_pkg::ST_IDLE && !dec_hit |=> !cmd_valid_q;
   endproperty
   a_nop: assert property (p_nop) else $error("no-op raised valid");
   property p_mode_register_fifteen_only;
      hh && r[9:8] == sgd_pkg::PAIR_HL && f[9:8] == sgd_pkg::PAIR_HL
         && (r[7:4] != sgd_pkg::MR_FIFTEEN || !training_mode) |=> !cmd_valid_q;
   endproperty
   a_mode_register_fifteen_only: assert property (p_mode_register_fifteen_only) else $error("illegal high-high write taken");
   property p_cat;
      lh && training_mode && st_q == sgd_pkg::ST_IDLE
         |=> cmd_valid_q && cmd_code_q == sgd_pkg::CMD_BUS_TRAINING_CAPTURE;
   endproperty
   a_cat: assert property (p_cat) else $error("training capture missed");
endmodule // sgd_ca_decoder
`default_nettype wire

//--- inc/sgd_pkg.sv
/*
 * shared constants for the command/address packet decoder: field slices,
 * pair encodings of the two top lines, command codes and sequencer states.
 * assumes the packet halves arrive already split into rising and falling words.
 */
`default_nettype none
package sgd_pkg;
   // ==========================================================================
   // bus widths and field slices
   localparam int CA_W = 10;
   localparam int LOW_W = 4;
   localparam int OP_HI = 9; // top two lines select the command family
   localparam int OP_LO = 8;
   localparam int SUB_HI = 7; // falling-edge sub-select
   localparam int SUB_LO = 6;
   localparam int BANK_HI = 7;
   localparam int BANK_LO = 4;
   localparam int LOW_HI = 3;
   localparam int COLHI_HI = 2;
   localparam int CE_BIT = 3; // pseudo-channel gate on falling edge
   localparam int ALL_BIT = 4; // all-bank / auto-close select on falling edge
   localparam int BYTE_HI = 7;
   localparam int MASK_W = 16;
   localparam int MR_N = 16;
   localparam int OP_W = 12;
   localparam logic [3:0] MR_FIFTEEN = 4'hf;
   // ==========================================================================
   // logical levels of the two top lines
   localparam logic [1:0] PAIR_LL = 2'h0;
   localparam logic [1:0] PAIR_LH = 2'h1;
   localparam logic [1:0] PAIR_HL = 2'h2;
   localparam logic [1:0] PAIR_HH = 2'h3;
   // ==========================================================================
   // decoded commands
   typedef enum logic [4:0] {
      CMD_NOP = 5'b00000,
      CMD_MODE_REGISTER_WRITE = 5'b00001,
      CMD_ROW_OPEN = 5'b00010,
      CMD_READ = 5'b00011,
      CMD_FIFO_LOAD = 5'b00100,
      CMD_READ_TRAIN = 5'b00101,
      CMD_WRITE = 5'b00110,
      CMD_WRITE_SHARED_MASK = 5'b00111,
      CMD_WRITE_PER_BYTE_MASK = 5'b01000,
      CMD_WRITE_TRAIN = 5'b01001,
      CMD_PRECHARGE_ONE_BANK = 5'b01010,
      CMD_PRECHARGE_ALL_BANKS = 5'b01011,
      CMD_REFRESH_ONE_BANK = 5'b01100,
      CMD_REFRESH_ALL_BANKS = 5'b01101,
      CMD_POWER_DOWN_ENTRY = 5'b01110,
      CMD_POWER_DOWN_EXIT = 5'b01111,
      CMD_SELF_REFRESH_ENTRY = 5'b10000,
      CMD_SELF_REFRESH_EXIT = 5'b10001,
      CMD_BUS_TRAINING_CAPTURE = 5'b10010
   } sgd_cmd_t;
   // mask collection after a masked write
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_MASK_A = 2'b01,
      ST_MASK_B = 2'b10
   } sgd_st_t;
endpackage
`default_nettype wire

//--- rtl/sgd_ca_uninvert.sv
/*
 * turns physical command/address levels back into logical values.
 * assumes the invert flag and its enable are sampled with the same word.
 */
`timescale 1ns/1ps
`default_nettype none
module sgd_ca_uninvert #(
   parameter int W = 10
) (
   input wire logic [W-1:0] raw,
   input wire logic inv_en,
   input wire logic flag_n,
   output logic [W-1:0] logical
);
   // ==========================================================================
   // a low flag with inversion enabled means every line arrived flipped
   assign logical = (inv_en && !flag_n) ? ~raw : raw;
endmodule // sgd_ca_uninvert
`default_nettype wire

//--- verification/sgd_ctrl_model.sv
/*
 * controller-side model: drives the physical command/address lines.
 * assumes the bench hands it logical packet halves at the rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module sgd_ctrl_model (
   input wire logic [9:0] log_rise,
   input wire logic [9:0] log_fall,
   input wire logic [3:0] log_pc1_rise,
   input wire logic [3:0] log_pc1_fall,
   input wire logic invert,
   output logic [9:0] ca_rise,
   output logic [9:0] ca_fall,
   output logic [3:0] pc1_ca_rise,
   output logic [3:0] pc1_ca_fall,
   output logic flag_n
);
   // ==========================================================================
   // line drive
   // every line carries a firm level on both edges, don't-care ones too
   // inverting the lines lowers the flag so the receiver can undo it
   assign flag_n = ~invert;
   assign ca_rise = invert ? ~log_rise : log_rise;
   assign ca_fall = invert ? ~log_fall : log_fall;
   assign pc1_ca_rise = invert ? ~log_pc1_rise : log_pc1_rise;
   assign pc1_ca_fall = invert ? ~log_pc1_fall : log_pc1_fall;
endmodule // sgd_ctrl_model
`default_nettype wire

//--- verification/test_sgd_ca_decoder.sv
/*
 * self-checking bench for the command/address packet decoder.
 * assumes the controller model sits between bench and decoder.
 */
`timescale 1ns/1ps
`default_nettype none
module test_sgd_ca_decoder;
   typedef struct packed {
      logic [9:0] r;
      logic [9:0] f;
      sgd_pkg::sgd_cmd_t code;
      logic vld;
      logic [3:0] bank;
   } sgd_row_t;
   localparam logic [9:0] NOP = 10'h3ff;
   logic sys_clk, resetn, cke_n, inv, inv_en, trn, pcm, flag_n, vq, ce0, ce1, ac, pd, sr, bn;
   logic [9:0] lr, lf, ca_r, ca_f, fd;
   logic [3:0] pr, pf, p1r, p1f, mr_sel, bank, mra, fpos;
   logic [13:0] row;
   logic [6:0] col0, col1;
   logic [11:0] mop, mrd;
   logic [15:0] m0, m1;
   sgd_pkg::sgd_cmd_t code;
   int err_count = 0;
   int checks = 0;
   int cyc = 0;
   sgd_row_t rows [13];

   sgd_ctrl_model sgd_ctrl_model_i (.log_rise(lr), .log_fall(lf), .log_pc1_rise(pr),
      .log_pc1_fall(pf), .invert(inv), .ca_rise(ca_r), .ca_fall(ca_f),
      .pc1_ca_rise(p1r), .pc1_ca_fall(p1f), .flag_n(flag_n));
   sgd_ca_decoder sgd_ca_decoder_i (.sys_clk(sys_clk), .resetn(resetn), .ca_rise(ca_r),
      .ca_fall(ca_f), .pc1_ca_rise(p1r), .pc1_ca_fall(p1f), .cke_n(cke_n),
      .cmd_bus_invert_flag_n(flag_n), .bus_invert_en(inv_en), .training_mode(trn),
      .pseudo_channel_mode(pcm), .mr_sel(mr_sel), .cmd_valid_q(vq), .cmd_code_q(code),
      .bank_q(bank), .row_q(row), .col_pc0_q(col0), .col_pc1_q(col1), .ce_pc0_q(ce0),
      .ce_pc1_q(ce1), .auto_close_q(ac), .mr_addr_q(mra), .mr_op_q(mop), .fifo_pos_q(fpos),
      .fifo_data_q(fd), .beat_mask0_q(m0), .beat_mask1_q(m1), .in_power_down_q(pd),
      .in_self_refresh_q(sr), .bad_nop_q(bn), .mr_rdata_q(mrd));

   // ==========================================================================
   // clock and hang guard; a stuck run counts as a mismatch
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         err_count++;
         results();
      end
   end

   // ==========================================================================
   // drivers: one packet per cycle, launched on the rising edge
   task automatic pkt(input logic [9:0] r, input logic [9:0] f, input logic ck);
      @(posedge sys_clk);
      lr <= r;
      lf <= f;
      cke_n <= ck;
   endtask
   // decode shows one cycle after the packet; idle follows so nothing repeats
   task automatic send(input logic [9:0] r, input logic [9:0] f, input logic ck);
      pkt(r, f, ck);
      pkt(NOP, NOP, ck);
      #1;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic results();
      if (err_count == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ==========================================================================
   // main sequence
   initial
   begin
      rows = '{'{10'h235, 10'h2aa, sgd_pkg::CMD_MODE_REGISTER_WRITE, 1'b1, 4'h3},
         '{10'h369, 10'h10b, sgd_pkg::CMD_READ, 1'b1, 4'h6},
         '{10'h369, 10'h11b, sgd_pkg::CMD_READ, 1'b1, 4'h6},
         '{10'h300, 10'h1c8, sgd_pkg::CMD_READ_TRAIN, 1'b1, 4'h0},
         '{10'h342, 10'h00f, sgd_pkg::CMD_WRITE, 1'b1, 4'h4},
         '{10'h342, 10'h01f, sgd_pkg::CMD_WRITE, 1'b1, 4'h4},
         '{10'h3c0, 10'h0c8, sgd_pkg::CMD_WRITE_TRAIN, 1'b1, 4'hc},
         '{10'h290, 10'h000, sgd_pkg::CMD_PRECHARGE_ONE_BANK, 1'b1, 4'h9},
         '{10'h290, 10'h010, sgd_pkg::CMD_PRECHARGE_ALL_BANKS, 1'b1, 4'h9},
         '{10'h270, 10'h100, sgd_pkg::CMD_REFRESH_ONE_BANK, 1'b1, 4'h7},
         '{10'h270, 10'h110, sgd_pkg::CMD_REFRESH_ALL_BANKS, 1'b1, 4'h7},
         '{NOP, NOP, sgd_pkg::CMD_NOP, 1'b0, 4'h0},
         '{NOP, 10'h140, sgd_pkg::CMD_NOP, 1'b0, 4'h0}};
      // idle tops 11/10 so the first cycle after reset decodes nothing
      {resetn, cke_n, inv, trn, pcm, inv_en} = 6'h01;
      {lr, lf, pr, pf, mr_sel} = {NOP, 10'h2ff, 12'h000};
      repeat (20) @(posedge sys_clk);
      chk("reset", 16'h0000, 16'({vq, pd, sr, bn, code}));
      resetn <= 1'b1;
      foreach (rows[i])
      begin
         send(rows[i].r, rows[i].f, 1'b0);
         chk("valid", 16'(rows[i].vld), 16'(vq));
         if (rows[i].vld)
         begin
            chk("code", 16'(rows[i].code), 16'(code));
            chk("bank", 16'(rows[i].bank), 16'(bank));
         end
      end
      send(10'h053, 10'h2a5, 1'b0);
      chk("row", 16'h2a53, 16'(row));
      chk("rowcmd", 16'h0025, 16'({code, bank}));
      send(10'h3a7, 10'h1b5, 1'b0);
      chk("fifo", 16'h2b57, 16'({code, fpos, fd}));
      mr_sel <= 4'h3;
      repeat (2) @(posedge sys_clk);
      #1 chk("mr3", 16'h0aa5, 16'(mrd));
      // gate low on channel 0, own column and gate high on channel 1
      pcm <= 1'b1;
      {pr, pf} <= 8'h5a;
      send(10'h369, 10'h103, 1'b0);
      chk("pc", 16'h9ce5, {vq, ce0, col0, ce1, col1[5:0]});
      // per-byte masks with auto close, then one shared mask
      pkt(10'h321, 10'h059, 1'b0);
      pkt(10'h3c3, 10'h35a, 1'b0);
      pkt(10'h30f, 10'h3f0, 1'b0);
      pkt(NOP, NOP, 1'b0);
      #1 chk("wpb", 16'h0068, 16'({vq, ac, code}));
      chk("m0", 16'h5ac3, m0);
      chk("m1", 16'hf00f, m1);
      pkt(10'h321, 10'h089, 1'b0);
      pkt(10'h312, 10'h3ab, 1'b0);
      pkt(NOP, NOP, 1'b0);
      #1 chk("wsm", 16'h0047, 16'({vq, ac, code}));
      chk("msh", 16'hab12, m0 & m1);
      inv <= 1'b1;
      send(10'h369, 10'h10b, 1'b0);
      chk("inv", 16'h0236, 16'({vq, code, bank}));
      inv <= 1'b0;
      send(NOP, NOP, 1'b1);
      chk("pde", 16'h006e, 16'({vq, pd, code}));
      send(NOP, NOP, 1'b0);
      chk("pdx", 16'h004f, 16'({vq, pd, code}));
      send(10'h200, 10'h100, 1'b1);
      chk("sre", 16'h0070, 16'({vq, sr, code}));
      send(NOP, NOP, 1'b0);
      chk("srx", 16'h0051, 16'({vq, sr, code}));
      trn <= 1'b1;
      send(NOP, NOP, 1'b1);
      chk("cat", 16'h0032, 16'({vq, code}));
      send(10'h2f1, 10'h2aa, 1'b1);
      chk("mode_register_fifteen", 16'h03e1, 16'({mra, vq, code}));
      chk("mr15op", 16'h0aa1, 16'(mop));
      send(NOP, 10'h2ff, 1'b0);
      send(NOP, 10'h2ff, 1'b0);
      chk("nop2", 16'h0000, 16'({vq, bn}));
      trn <= 1'b0;
      send(NOP, 10'h2ff, 1'b0);
      chk("badnop", 16'h0001, 16'({vq, bn}));
      // third no-op encoding: tops 10 on rising, 11 on falling
      send(10'h2ff, NOP, 1'b0);
      chk("badnop3", 16'h0001, 16'({vq, bn}));
      send(NOP, 10'h2ff, 1'b1);
      send(10'h2f1, 10'h2aa, 1'b1);
      chk("mr15x", 16'h0000, 16'(vq));
      results();
   end
endmodule // test_sgd_ca_decoder
`default_nettype wire
